/* dv/msdl_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module msdl_chk (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire msdl_pkg::msdl_pin_in_s pins_i,
  input wire logic spd_err_o,
  input wire logic spd_err_oe_o,
  input wire logic lock_flag_out_o,
  input wire logic lock_flag_out_oe_o,
  input wire logic duty_pulse_o,
  input wire logic duty_pulse_oe_o,
  input wire msdl_pkg::msdl_power_s power_o
);
  import msdl_pkg::*;
  logic tach_q;
  logic [15:0] rise_q;
  logic [8:0] lim_q;
  // clocks since the raw tach rise; the design sees it a few clocks later
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tach_q <= 1'b0;
      rise_q <= 16'h0000;
    end else begin
      tach_q <= pins_i.tach;
      if (pins_i.tach && !tach_q) rise_q <= 16'h0000;
      else if (rise_q != 16'hFFFF) rise_q <= rise_q + 16'h0001;
    end
  end
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) lim_q <= 9'h000;
    else if (!pins_i.lim2) lim_q <= 9'h000;
    else if (lim_q != 9'h1FF) lim_q <= lim_q + 9'h001;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  AST_STOP_OFF:
    assert property (!pins_i.run_ctl [*8] |-> power_o == 4'h0 && !spd_err_oe_o
      && !lock_flag_out_oe_o) else $error("outputs live in stop");
  AST_RUN_ON:
    assert property (pins_i.run_ctl [*8] |-> power_o.drive_en && power_o.reg5v_en
      && power_o.tach_bias_en) else $error("supplies off in run");
  AST_LIMIT1:
    assert property ((pins_i.run_ctl && pins_i.lim1) [*8] |-> power_o.drive_limit)
      else $error("limiter one idle");
  AST_DUTY_OFF:
    assert property (!pins_i.pwm [*8] |-> !duty_pulse_oe_o) else $error("duty without pwm");
  AST_DUTY_ON:
    assert property ((pins_i.run_ctl && pins_i.pwm && !pins_i.lim2) [*8] |-> duty_pulse_oe_o)
      else $error("duty blocked");
  AST_LIM2_CUT:
    assert property (lim_q >= 9'h0D2 |-> !duty_pulse_oe_o) else $error("limiter two late");
  AST_OC_LOW:
    assert property (!lock_flag_out_o && !duty_pulse_o) else $error("open collector high");
  AST_DECEL_RISE:
    assert property ($rose(spd_err_oe_o) && !spd_err_o |-> rise_q <= 16'h000C)
      else $error("decel off period edge");
  AST_LOCK_RISE:
    assert property ($rose(lock_flag_out_oe_o) |-> rise_q <= 16'h000C)
      else $error("lock off period edge");
  AST_ACCEL_LATE:
    assert property ($rose(spd_err_oe_o) && spd_err_o |-> rise_q >= 16'h3FE8)
      else $error("accel too early");
  cover property ($rose(spd_err_oe_o) && spd_err_o);
  cover property ($rose(spd_err_oe_o) && !spd_err_o);
  cover property ($rose(lock_flag_out_oe_o));
endmodule
bind msdl_core msdl_chk u_chk (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .pins_i(pins_i),
  .spd_err_o(spd_err_o), .spd_err_oe_o(spd_err_oe_o), .lock_flag_out_o(lock_flag_out_o),
  .lock_flag_out_oe_o(lock_flag_out_oe_o), .duty_pulse_o(duty_pulse_o),
  .duty_pulse_oe_o(duty_pulse_oe_o), .power_o(power_o));
`default_nettype wire

/* dv/msdl_core_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module msdl_core_tb;
  import msdl_pkg::*;
  logic clk, rstn, tach, spin, run, lim1, lim2, pwm;
  logic err, err_oe, lk, lk_oe, dp, dp_oe;
  logic [15:0] per;
  msdl_pin_in_s pins;
  msdl_power_s pwr;
  int fails = 0;
  int total_checks = 0;
  assign pins = {tach, run, lim1, lim2, pwm};
  msdl_core DUT (.core_clk_i(clk), .rstn_i(rstn), .pins_i(pins), .spd_err_o(err),
    .spd_err_oe_o(err_oe), .lock_flag_out_o(lk), .lock_flag_out_oe_o(lk_oe),
    .duty_pulse_o(dp), .duty_pulse_oe_o(dp_oe), .power_o(pwr));
  msdl_tach_model u_tach (.core_clk_i(clk), .spin_i(spin), .period_i(per), .tach_o(tach));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (!ok) begin
      fails++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic give_verdict();
    if (fails == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // one tick is 8 clocks, so 16800 clocks is 2100 ticks
  task automatic t_speed();
    per = 16'h41A0;
    spin = 1'b1;
    @(posedge tach);
    cyc(16790);
    chk(err_oe === 1'b1 && err === 1'b1, "no accel");
    @(posedge tach);
    per = 16'h3E80;
    cyc(12);
    chk(lk_oe === 1'b1 && err_oe === 1'b0, "lock or accel end");
    @(posedge tach);
    per = 16'h1F40;
    cyc(12);
    chk(err_oe === 1'b1 && err === 1'b0 && lk_oe === 1'b1, "no decel");
    cyc(340);
    chk(err_oe === 1'b1, "decel short");
    cyc(45);
    chk(err_oe === 1'b0, "decel long");
    @(posedge tach);
    cyc(12);
    chk(err_oe === 1'b1 && err === 1'b0 && lk_oe === 1'b0, "lock kept");
  endtask
  task automatic t_stop();
    lim1 = 1'b1;
    cyc(8);
    chk(pwr === 4'hF, "limit one");
    run = 1'b0;
    cyc(8);
    chk(pwr === 4'h0 && err_oe === 1'b0 && lk_oe === 1'b0, "stop");
    lim1 = 1'b0;
  endtask
  task automatic t_lim2();
    run = 1'b1;
    pwm = 1'b1;
    cyc(10);
    chk(dp_oe === 1'b1, "duty off");
    lim2 = 1'b1;
    cyc(190);
    chk(dp_oe === 1'b1, "limit two early");
    cyc(25);
    chk(dp_oe === 1'b0, "limit two late");
    lim2 = 1'b0;
    cyc(8);
    chk(dp_oe === 1'b1, "limit two stuck");
    pwm = 1'b0;
    cyc(8);
    chk(dp_oe === 1'b0, "pwm ignored");
  endtask
  initial begin
    rstn = 1'b0;
    run = 1'b0;
    spin = 1'b0;
    lim1 = 1'b0;
    lim2 = 1'b0;
    pwm = 1'b0;
    per = 16'h0000;
    cyc(5);
    chk(pwr === 4'h0 && err_oe === 1'b0 && lk_oe === 1'b0 && dp_oe === 1'b0, "reset");
    pwm = 1'b1;
    rstn = 1'b1;
    cyc(10);
    chk(pwr === 4'h0 && err_oe === 1'b0 && dp_oe === 1'b0, "run low not held");
    run = 1'b1;
    cyc(20);
    t_speed();
    t_stop();
    t_lim2();
    give_verdict();
  end
  initial begin
    #4500000;
    fails++;
    give_verdict();
  end
endmodule
`default_nettype wire

/* dv/msdl_tach_model.sv */
`timescale 1ns/1ps
`default_nettype none
module msdl_tach_model (
  input wire logic core_clk_i,
  input wire logic spin_i,
  input wire logic [15:0] period_i,
  output logic tach_o
);
  logic [15:0] ph_q;
  // a rotor at rest gives no tach edges, so the line stays low
  always_ff @(posedge core_clk_i) begin
    if (!spin_i || ph_q >= period_i - 16'h0001) ph_q <= 16'h0000;
    else ph_q <= ph_q + 16'h0001;
  end
  assign tach_o = spin_i && (ph_q < {1'b0, period_i[15:1]});
endmodule
`default_nettype wire

/* src/msdl_core.sv */
// Functional notes
// - count 2046 divided clocks per tach period
// - one-count resolution error each period, charge-pump
// - error pin high accelerates, low decelerates
// - error pin floats when neither request active
// - reference divided by eight before counting
// - locked within 3.13 percent of target
// - lock pin pulled low while locked
// - stop turns off drive and regulators
// - slow run rise holds logic reset
// - lock never shows until first full tach period
// - secondary limit restricts duty-pulse on-time
// - primary limiter first, secondary after delay
`timescale 1ns/1ps
`default_nettype none

module msdl_core (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire msdl_pkg::msdl_pin_in_s pins_i,
  output logic spd_err_o,
  output logic spd_err_oe_o,
  output logic lock_flag_out_o,
  output logic lock_flag_out_oe_o,
  output logic duty_pulse_o,
  output logic duty_pulse_oe_o,
  output msdl_pkg::msdl_power_s power_o
);
  import msdl_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [PIN_N-1:0] raw;
  logic [PIN_N-1:0] stable_q;
  msdl_pin_in_s pin_s;

  assign raw = pins_i;
  assign pin_s = stable_q;

  // two flops settle the pin, the third confirms the level
  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_sync
      logic s1_q;
      logic s2_q;
      logic s3_q;
      always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end else begin
          s1_q <= raw[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      // only a level seen twice in a row counts, so glitches are ignored
      always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          stable_q[gi] <= 1'b0;
        end else if (s2_q == s3_q) begin
          stable_q[gi] <= s3_q;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // run control and logic hold
  // ---------------------------------------------------------------
  logic run;
  logic hold;

  // a slowly rising run input keeps all but the synchronisers and tach_prev_q cleared until it is high
  assign run = pin_s.run_ctl;
  assign hold = !run;

  // ---------------------------------------------------------------
  // reference divider
  // ---------------------------------------------------------------
  logic [2:0] div_q;
  logic tick;

  // restarted on hold so the first tick after run is a whole one
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_q <= 3'h0;
    end else if (hold) begin
      div_q <= 3'h0;
    end else if (div_q == DIV_LAST) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end

  assign tick = (div_q == DIV_LAST);

  // ---------------------------------------------------------------
  // tach edge detect
  // ---------------------------------------------------------------
  logic tach_prev_q;
  logic tach_rise;

  // follows the pin even while held, so a high tach at release is no edge
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tach_prev_q <= 1'b0;
    end else begin
      tach_prev_q <= pin_s.tach;
    end
  end

  assign tach_rise = pin_s.tach && !tach_prev_q;

  // ---------------------------------------------------------------
  // period counter
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] per_cnt_q;
  logic seen_q;

  // saturates rather than wraps so a stalled motor still reads slow
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      per_cnt_q <= CNT_RST;
    end else if (hold || tach_rise) begin
      per_cnt_q <= CNT_RST;
    end else if (tick && per_cnt_q != CNT_MAX) begin
      per_cnt_q <= per_cnt_q + 12'h001;
    end
  end

  // first edge only starts a measurement
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      seen_q <= 1'b0;
    end else if (hold) begin
      seen_q <= 1'b0;
    end else if (tach_rise) begin
      seen_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // deceleration pulse
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] dec_left_q;
  logic dec_act;
  logic acc_act;

  // an early edge leaves a decel pulse as long as the shortfall
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dec_left_q <= CNT_RST;
    end else if (hold) begin
      dec_left_q <= CNT_RST;
    end else if (tach_rise && seen_q && per_cnt_q < TARGET_CNT) begin
      dec_left_q <= TARGET_CNT - per_cnt_q;
    end else if (tick && dec_left_q != CNT_RST) begin
      dec_left_q <= dec_left_q - 12'h001;
    end
  end

  // decel stands until the shortfall has been paid back in ticks
  assign dec_act = (dec_left_q != CNT_RST);
  // a late edge: accelerate from the target count until the edge
  assign acc_act = seen_q && (per_cnt_q >= TARGET_CNT) && !tach_rise;

  // ---------------------------------------------------------------
  // speed error pin
  // ---------------------------------------------------------------
  logic spd_err_q;
  logic spd_err_oe_q;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      spd_err_q <= 1'b0;
    end else if (hold) begin
      spd_err_q <= 1'b0;
    end else begin
      spd_err_q <= acc_act;
    end
  end

  // enable falls once neither request stands, so the pin floats
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      spd_err_oe_q <= 1'b0;
    end else if (hold) begin
      spd_err_oe_q <= 1'b0;
    end else begin
      spd_err_oe_q <= acc_act || dec_act;
    end
  end

  assign spd_err_o = spd_err_q;
  assign spd_err_oe_o = spd_err_oe_q;

  // ---------------------------------------------------------------
  // lock detect
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] err_mag;
  logic in_range;
  logic lock_q;

  // distance from target on the count that the edge is closing
  always_comb begin
    if (per_cnt_q >= TARGET_CNT) begin
      err_mag = per_cnt_q - TARGET_CNT;
    end else begin
      err_mag = TARGET_CNT - per_cnt_q;
    end
  end

  // 64 counts either side is the nearest whole count to the lock band
  assign in_range = (err_mag <= LOCK_TOL);

  // cleared at reset, so it never shows before the first period closes
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lock_q <= 1'b0;
    end else if (hold) begin
      lock_q <= 1'b0;
    end else if (tach_rise && seen_q) begin
      lock_q <= in_range;
    end
  end

  assign lock_flag_out_o = 1'b0;
  assign lock_flag_out_oe_o = lock_q;

  // ---------------------------------------------------------------
  // secondary current limiter
  // ---------------------------------------------------------------
  logic [LIM_W-1:0] lim2_cnt_q;
  logic lim2_act_q;

  // counts how long the secondary sense has stood over its threshold
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lim2_cnt_q <= LIM_RST;
    end else if (hold || !pin_s.lim2) begin
      lim2_cnt_q <= LIM_RST;
    end else if (lim2_cnt_q != LIM2_LAST) begin
      lim2_cnt_q <= lim2_cnt_q + 10'h001;
    end
  end

  // waits out the regulator delay so the primary limiter acts first
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lim2_act_q <= 1'b0;
    end else if (hold || !pin_s.lim2) begin
      lim2_act_q <= 1'b0;
    end else if (lim2_cnt_q == LIM2_LAST) begin
      lim2_act_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // duty-pulse output
  // ---------------------------------------------------------------
  logic duty_on_q;

  // limitation: on-time is cut whole while limited, not trimmed
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      duty_on_q <= 1'b0;
    end else begin
      duty_on_q <= run && pin_s.pwm && !lim2_act_q;
    end
  end

  assign duty_pulse_o = 1'b0;
  assign duty_pulse_oe_o = duty_on_q;

  // ---------------------------------------------------------------
  // drive and regulator enables
  // ---------------------------------------------------------------
  msdl_power_s power_q;

  // a stop drops the regulators too, so the tach bias goes with it
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      power_q <= POWER_RST;
    end else begin
      power_q.drive_en <= run;
      power_q.drive_limit <= run && pin_s.lim1;
      power_q.tach_bias_en <= run;
      power_q.reg5v_en <= run;
    end
  end

  assign power_o = power_q;

endmodule

`default_nettype wire

/* src/msdl_pkg.sv */
`default_nettype none

package msdl_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned LIM2_DELAY_NS = 10000;
  localparam int unsigned LIM2_DELAY_CYC = (LIM2_DELAY_NS * (CLK_HZ / 1000000)) / 1000;

  // ---------------------------------------------------------------
  // speed discriminator
  // ---------------------------------------------------------------
  localparam int unsigned DIV_RATIO = 8;
  localparam int unsigned CNT_W = 12;
  localparam logic [2:0] DIV_LAST = 3'(DIV_RATIO - 1);
  localparam logic [CNT_W-1:0] TARGET_CNT = 12'h7FE;
  localparam logic [CNT_W-1:0] LOCK_TOL = 12'h040;
  localparam logic [CNT_W-1:0] CNT_MAX = 12'hFFF;
  localparam logic [CNT_W-1:0] CNT_RST = 12'h000;

  // ---------------------------------------------------------------
  // secondary limiter delay counter
  // ---------------------------------------------------------------
  localparam int unsigned LIM_W = 10;
  localparam logic [LIM_W-1:0] LIM2_LAST = LIM_W'(LIM2_DELAY_CYC - 1);
  localparam logic [LIM_W-1:0] LIM_RST = 10'h000;

  // ---------------------------------------------------------------
  // pin groups
  // ---------------------------------------------------------------
  localparam int unsigned PIN_N = 5;

  typedef struct packed {
    logic tach;
    logic run_ctl;
    logic lim1;
    logic lim2;
    logic pwm;
  } msdl_pin_in_s;

  typedef struct packed {
    logic drive_en;
    logic drive_limit;
    logic tach_bias_en;
    logic reg5v_en;
  } msdl_power_s;

  localparam msdl_pin_in_s PIN_RST = 5'h00;
  localparam msdl_power_s POWER_RST = 4'h0;

endpackage

`default_nettype wire
